// ===== include/drit_defs.vh
// Function
// [R1] A 3-bit clock-select field at bits 10 to 8 picks one of seven divided clocks, code 010 being divide by eight.
// [R2] The counter stays idle until a clock is selected and starts counting as soon as one is.
// [R3] Bit 7 enables refresh cycle generation when 1 and disables it when 0.
// [R4] The refresh counter is 8 bits wide and increments by one on each selected clock tick.
// [R5] On each count the counter is compared with the interval constant; on equality the flag sets and the counter clears to zero.
// [R6] A compare match with refresh enabled produces one refresh request; with it disabled, none.
// [R7] An 8-bit software-writable interval constant sets the count at which a match occurs.
// [R8] The compare-match flag stays set until software writes 0 after reading it as 1.
`ifndef DRIT_DEFS_VH
`define DRIT_DEFS_VH

// Bus and counter widths
`define DRIT_ADDR_W 24
`define DRIT_DATA_W 16
`define DRIT_CNT_W 8

// Register addresses
`define DRIT_ADDR_CTRL 24'hFFFDA6
`define DRIT_ADDR_CNT 24'hFFFDA8
`define DRIT_ADDR_CONST 24'hFFFDA9

// Control register field layout
`define DRIT_FLAG_BIT 15
`define DRIT_SEL_HI 10
`define DRIT_SEL_LO 8
`define DRIT_ENA_BIT 7

// Reset values
`define DRIT_CTRL_RST 16'h0000
`define DRIT_CNT_RST 8'h00
`define DRIT_CONST_RST 8'h00

// Clock select codes
`define DRIT_SEL_W 3
`define DRIT_SEL_OFF 3'h0
`define DRIT_SEL_D2 3'h1
`define DRIT_SEL_D8 3'h2
`define DRIT_SEL_D32 3'h3
`define DRIT_SEL_D128 3'h4
`define DRIT_SEL_D512 3'h5
`define DRIT_SEL_D2048 3'h6
`define DRIT_SEL_D4096 3'h7

// Low prescaler bits that must all be ones for a tick, per division
`define DRIT_LOG_OFF 0
`define DRIT_LOG_D2 1
`define DRIT_LOG_D8 3
`define DRIT_LOG_D32 5
`define DRIT_LOG_D128 7
`define DRIT_LOG_D512 9
`define DRIT_LOG_D2048 11
`define DRIT_LOG_D4096 12

// Prescaler width, enough for the largest division
`define DRIT_PRE_W 12

`endif

// ===== design/drit_prescaler.v
`timescale 1ns/100ps
`include "drit_defs.vh"

module drit_prescaler
#(
    parameter PRE_W = `DRIT_PRE_W
)
(
    // Clock and reset
    input wire i_clock,
    input wire i_rst_n,
    // Selection
    input wire [`DRIT_SEL_W-1:0] i_sel,
    // Divided clock enable
    output reg o_tick
);

    reg [PRE_W-1:0] pre_reg;
    reg [PRE_W-1:0] mask;

    ////////////////////////////////////////////////////////////////////////
    // Low bits of the free-running count that must all be ones per tick
    function [PRE_W-1:0] div_mask;
        input [`DRIT_SEL_W-1:0] sel;
        integer lg;
        begin
            case (sel)
                `DRIT_SEL_D2:    lg = `DRIT_LOG_D2;
                `DRIT_SEL_D8:    lg = `DRIT_LOG_D8;
                `DRIT_SEL_D32:   lg = `DRIT_LOG_D32;
                `DRIT_SEL_D128:  lg = `DRIT_LOG_D128;
                `DRIT_SEL_D512:  lg = `DRIT_LOG_D512;
                `DRIT_SEL_D2048: lg = `DRIT_LOG_D2048;
                `DRIT_SEL_D4096: lg = `DRIT_LOG_D4096;
                default:         lg = `DRIT_LOG_OFF;
            endcase
            // Shifting the whole width out leaves no bit set when stopped
            div_mask = {PRE_W{1'b1}} >> (PRE_W - lg);
        end
    endfunction

    // Decode of the division (the 010 code gives divide by eight)
    always @*
    begin
        mask = div_mask(i_sel); // [R1]
    end

    ////////////////////////////////////////////////////////////////////////
    // Free-running divider and one-cycle registered tick; none is launched while stopped
    always @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pre_reg <= {PRE_W{1'b0}};
            o_tick <= 1'b0;
        end
        else
        begin
            pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
            o_tick <= (i_sel != `DRIT_SEL_OFF) &&
                      ((pre_reg & mask) == mask); // [R2]
        end
    end

endmodule

// ===== design/drit_timer.v
`timescale 1ns/100ps
`include "drit_defs.vh"

module drit_timer
#(
    parameter ADDR_W = `DRIT_ADDR_W,
    parameter DATA_W = `DRIT_DATA_W,
    parameter CNT_W = `DRIT_CNT_W
)
(
    // Clock and reset
    input wire i_clock,
    input wire i_rst_n,
    // Register port
    input wire [ADDR_W-1:0] i_addr,
    input wire [DATA_W-1:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [DATA_W-1:0] o_rdata,
    // Toward the DRAM bus cycle logic
    output reg o_refresh_req,
    // Status
    output reg o_compare_match_flag
);

    ////////////////////////////////////////////////////////////////////////
    // Storage

    reg [`DRIT_SEL_W-1:0] refresh_clock_select_reg;
    reg [`DRIT_SEL_W-1:0] refresh_clock_select_next;
    reg refresh_generation_enable_reg;
    reg refresh_generation_enable_next;
    reg [CNT_W-1:0] refresh_counter_reg;
    reg [CNT_W-1:0] refresh_counter_next;
    reg [CNT_W-1:0] refresh_interval_constant_reg;
    reg [CNT_W-1:0] refresh_interval_constant_next;
    reg compare_match_flag_next;
    reg flag_armed_reg;
    reg flag_armed_next;
    reg refresh_req_next;
    reg [DATA_W-1:0] rdata_next;

    wire tick;
    wire pre_tick;
    wire wr_ctrl;
    wire wr_cnt;
    wire wr_const;
    wire rd_ctrl;
    wire match;

    ////////////////////////////////////////////////////////////////////////
    // Address decode of the three registers
    assign wr_ctrl = i_wr && (i_addr == `DRIT_ADDR_CTRL);
    assign wr_cnt = i_wr && (i_addr == `DRIT_ADDR_CNT);
    assign wr_const = i_wr && (i_addr == `DRIT_ADDR_CONST);
    assign rd_ctrl = i_rd && (i_addr == `DRIT_ADDR_CTRL);

    ////////////////////////////////////////////////////////////////////////
    // Divided clock enable for the counter
    drit_prescaler
    #(
        .PRE_W(`DRIT_PRE_W)
    )
    u_prescaler
    (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_sel(refresh_clock_select_reg),
        .o_tick(pre_tick)
    );

    // Counting ticks; a tick already launched when software stops the
    // clock is dropped, so the counter freezes at the write edge
    assign tick = pre_tick &&
        (refresh_clock_select_reg != `DRIT_SEL_OFF); // [R2]

    // Compare on each count against the interval constant;
    // a counter that already passed the constant wraps through zero
    assign match = tick &&
        (refresh_counter_reg == refresh_interval_constant_reg); // [R5]

    ////////////////////////////////////////////////////////////////////////
    // Control register fields
    always @*
    begin
        refresh_clock_select_next = refresh_clock_select_reg;
        refresh_generation_enable_next = refresh_generation_enable_reg;
        if (wr_ctrl)
        begin
            refresh_clock_select_next =
                i_wdata[`DRIT_SEL_HI:`DRIT_SEL_LO]; // [R1]
            refresh_generation_enable_next =
                i_wdata[`DRIT_ENA_BIT]; // [R3]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interval constant, written by software
    always @*
    begin
        refresh_interval_constant_next = refresh_interval_constant_reg;
        if (wr_const)
        begin
            refresh_interval_constant_next = i_wdata[CNT_W-1:0]; // [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Refresh counter: software write first, then clear on match,
    // else count on each tick
    // Write of the counter wins so software can reposition the interval
    always @*
    begin
        refresh_counter_next = refresh_counter_reg;
        if (wr_cnt)
        begin
            refresh_counter_next = i_wdata[CNT_W-1:0];
        end
        else if (match)
        begin
            refresh_counter_next = `DRIT_CNT_RST; // [R5]
        end
        else if (tick)
        begin
            refresh_counter_next = refresh_counter_reg +
                {{(CNT_W-1){1'b0}}, 1'b1}; // [R4] [R2]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare-match flag: a read seeing 1 arms the clear, a later write
    // of 0 clears it; a match in the same cycle wins
    // Arming keeps a stray write of 0 from losing a match that software
    // has not seen yet
    always @*
    begin
        compare_match_flag_next = o_compare_match_flag;
        flag_armed_next = flag_armed_reg;
        if (rd_ctrl && o_compare_match_flag)
        begin
            flag_armed_next = 1'b1;
        end
        if (wr_ctrl && !i_wdata[`DRIT_FLAG_BIT] && flag_armed_reg)
        begin
            compare_match_flag_next = 1'b0; // [R8]
            flag_armed_next = 1'b0;
        end
        if (match)
        begin
            compare_match_flag_next = 1'b1; // [R5] [R8]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One refresh request pulse per match, only while enabled
    // Registered so the request rises with the flag at the match edge
    always @*
    begin
        refresh_req_next = match && refresh_generation_enable_reg; // [R6]
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid the cycle after the read strobe
    // Unmapped addresses read as zero
    always @*
    begin
        rdata_next = {DATA_W{1'b0}};
        if (i_rd)
        begin
            case (i_addr)
                `DRIT_ADDR_CTRL:
                begin
                    rdata_next[`DRIT_FLAG_BIT] = o_compare_match_flag;
                    rdata_next[`DRIT_SEL_HI:`DRIT_SEL_LO] =
                        refresh_clock_select_reg;
                    rdata_next[`DRIT_ENA_BIT] =
                        refresh_generation_enable_reg;
                end
                `DRIT_ADDR_CNT:
                begin
                    rdata_next[CNT_W-1:0] = refresh_counter_reg;
                end
                `DRIT_ADDR_CONST:
                begin
                    rdata_next[CNT_W-1:0] = refresh_interval_constant_reg;
                end
                default:
                begin
                    rdata_next = {DATA_W{1'b0}};
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            refresh_clock_select_reg <= `DRIT_SEL_OFF;
            refresh_generation_enable_reg <= 1'b0;
            refresh_counter_reg <= `DRIT_CNT_RST;
            refresh_interval_constant_reg <= `DRIT_CONST_RST;
            o_compare_match_flag <= 1'b0;
            flag_armed_reg <= 1'b0;
            o_refresh_req <= 1'b0;
            o_rdata <= {DATA_W{1'b0}};
        end
        else
        begin
            refresh_clock_select_reg <= refresh_clock_select_next;
            refresh_generation_enable_reg <= refresh_generation_enable_next;
            refresh_counter_reg <= refresh_counter_next;
            refresh_interval_constant_reg <= refresh_interval_constant_next;
            o_compare_match_flag <= compare_match_flag_next;
            flag_armed_reg <= flag_armed_next;
            o_refresh_req <= refresh_req_next;
            o_rdata <= rdata_next;
        end
    end

endmodule

// ===== tb/drit_timer_chk.sv
`timescale 1ns/100ps
`include "drit_defs.vh"
module drit_timer_chk (
    // Clock and reset
    input logic i_clock,
    input logic i_rst_n,
    // Register port
    input logic [23:0] i_addr,
    input logic [15:0] i_wdata,
    input logic i_wr,
    input logic i_rd,
    input logic [15:0] o_rdata,
    // Outputs
    input logic o_refresh_req,
    input logic o_compare_match_flag
);
    logic [2:0] sel_reg;
    logic ena_reg;
    logic ctrl_wr;
    logic [15:0] ctrl_img;
    assign ctrl_wr = i_wr && i_addr == `DRIT_ADDR_CTRL;
    assign ctrl_img = {o_compare_match_flag, 4'h0, sel_reg, ena_reg, 7'h00};
    // Shadow of select and enable fields
    always @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sel_reg <= 3'h0;
            ena_reg <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            sel_reg <= i_wdata[10:8];
            ena_reg <= i_wdata[7];
        end
    end
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    a_req_single: assert property (o_refresh_req |=> !o_refresh_req)
        else $error("refresh request longer than one cycle");
    a_req_flag: assert property (o_refresh_req |->
        o_compare_match_flag)
        else $error("refresh request without match flag");
    a_flag_sticky: assert property ($fell(o_compare_match_flag) |->
        $past(ctrl_wr) && !$past(i_wdata[15]))
        else $error("match flag cleared without software write");
    a_req_follows: assert property ($rose(o_compare_match_flag)
        && $past(ena_reg) |-> o_refresh_req)
        else $error("enabled match gave no refresh request");
    a_req_gated: assert property (o_refresh_req |-> $past(ena_reg))
        else $error("refresh request while disabled");
    a_sel_frozen: assert property ($rose(o_compare_match_flag)
        |-> $past(sel_reg) != 3'h0)
        else $error("match while counter clock stopped");
    a_ctrl_read: assert property ($past(i_rd) &&
        $past(i_addr) == `DRIT_ADDR_CTRL |-> o_rdata == $past(ctrl_img))
        else $error("control read value wrong");
    a_cnt_width: assert property ($past(i_rd) &&
        $past(i_addr) == `DRIT_ADDR_CNT |-> o_rdata[15:8] == 8'h00)
        else $error("counter wider than eight bits");
endmodule
bind drit_timer drit_timer_chk u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_refresh_req(o_refresh_req),
    .o_compare_match_flag(o_compare_match_flag));

// ===== tb/drit_refresh_sink.sv
`timescale 1ns/100ps
module drit_refresh_sink (
    // Clock and reset
    input logic i_clock,
    input logic i_rst_n,
    // Request and cycles run
    input logic i_refresh_req,
    output int o_done
);
    // One refresh cycle per request pulse
    always @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_done <= 0;
        else if (i_refresh_req)
            o_done <= o_done + 1;
    end
endmodule

// ===== tb/test_dram_refresh_interval_timer.sv
`timescale 1ns/100ps
`include "drit_defs.vh"
module test_dram_refresh_interval_timer;
    localparam logic [23:0] AC = `DRIT_ADDR_CTRL;
    localparam logic [23:0] AN = `DRIT_ADDR_CNT;
    localparam logic [23:0] AK = `DRIT_ADDR_CONST;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [23:0] i_addr = 24'h000000;
    logic [15:0] i_wdata = 16'h0000;
    wire [15:0] o_rdata;
    wire o_refresh_req;
    wire o_compare_match_flag;
    int done, mismatches = 0, checks_done = 0, n, m, i;
    initial forever #2 i_clock = ~i_clock;
    drit_timer uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_refresh_req(o_refresh_req),
        .o_compare_match_flag(o_compare_match_flag));
    drit_refresh_sink u_sink (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_refresh_req(o_refresh_req), .o_done(done));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [23:0] a, input logic [15:0] e);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    // Cycles until the next refresh request, bounded
    task wreq(output int c);
        c = 0;
        do
        begin
            @(posedge i_clock);
            #1 c++;
        end while (o_refresh_req !== 1'b1 && c < 10000);
        if (o_refresh_req !== 1'b1)
        begin
            mismatches++;
            $display("[FAIL] %0t no refresh request in time", $time);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #240000;
        mismatches++;
        results;
    end
    // Main sequence
    initial
    begin
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd(AC, 16'h0000);
        rd(24'hFFFDA7, 16'h0000);
        wr(AK, 16'h0003);
        wr(24'hFFFDA7, 16'h00FF);
        rd(AK, 16'h0003);
        repeat (40) @(posedge i_clock);
        rd(AN, 16'h0000);
        wr(AC, 16'h0280);
        wreq(n);
        wreq(n);
        chk(n[15:0], 16'h0020);
        chk({15'h0000, o_compare_match_flag}, 16'h0001);
        repeat (18) @(posedge i_clock);
        rd(AN, 16'h0002);
        wr(AC, 16'h0280);
        #1 chk({15'h0000, o_compare_match_flag}, 16'h0001);
        rd(AC, 16'h8280);
        wr(AC, 16'h0280);
        #1 chk({15'h0000, o_compare_match_flag}, 16'h0000);
        wr(AC, 16'h0200);
        m = done;
        repeat (80) @(posedge i_clock);
        chk(16'(done - m), 16'h0000);
        rd(AC, 16'h8200);
        wr(AK, 16'h0000);
        for (i = 1; i < 8; i++)
        begin
            wr(AC, {5'h00, i[2:0], 1'b1, 7'h00});
            wreq(n);
            wreq(n);
            wreq(n);
            chk(n[15:0], (i == 7) ? 16'h1000 :
                16'h0001 << (2 * i - 1));
        end
        wr(AC, 16'h0000);
        wr(AN, 16'h0005);
        repeat (50) @(posedge i_clock);
        rd(AN, 16'h0005);
        results;
    end
endmodule
